// File: include/bfs_defines.svh
// Constants of the boot flash section control block: register map, field
// positions, reset values, region sizes in flash words.
// Assumes word-addressed flash and an 8-bit register port.
`ifndef BFS_DEFINES_SVH
`define BFS_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define BFS_AW              15
`define BFS_DW              8
`define BFS_RAW             2

// ****************************************************************
// Register offsets
// ****************************************************************
`define BFS_REG_CTRL        2'h0
`define BFS_REG_LOCK        2'h1
`define BFS_REG_FUSE        2'h2

// ****************************************************************
// Control and status fields
// ****************************************************************
`define BFS_CTRL_BUSY       0
`define BFS_CTRL_CLEAR      1
`define BFS_CTRL_ACTIVE     2
`define BFS_CTRL_STALL      3
`define BFS_CTRL_READY      4

// Lock register: application set low, boot set high; bit 0 of a set
// low means store-program may not write that region
`define BFS_LOCK_APP_LSB    0
`define BFS_LOCK_BOOT_LSB   2
`define BFS_LOCK_WR_BIT     0
`define BFS_LOCK_RESET      2'h3

// Fuse view: size in [1:0], reset-vector fuse in 2, ready in 3
`define BFS_FUSE_RST_BIT    2
`define BFS_FUSE_READY_BIT  3
`define BFS_FUSE_SIZE_RESET 2'h3

// ****************************************************************
// Region sizes (words) and timing
// ****************************************************************
`define BFS_BOOT_WORDS_0    15'h1000
`define BFS_BOOT_WORDS_1    15'h0800
`define BFS_BOOT_WORDS_2    15'h0400
`define BFS_BOOT_WORDS_3    15'h0200
`define BFS_HALT_WORDS      15'h1000
`define BFS_APP_RESET_ADDR  15'h0000
`define BFS_FUSE_SETTLE     2'h2

`endif

// File: include/bfs_pkg.sv
// Types shared by the boot flash section control block.
// Assumes bfs_defines.svh is on the include path.
`include "bfs_defines.svh"

package bfs_pkg;

	typedef enum logic {
		BFS_OP_ERASE,
		BFS_OP_WRITE
	} bfs_op_t;

	typedef enum logic [1:0] {
		BFS_IDLE,
		BFS_RUN_CRR,
		BFS_RUN_HALT
	} bfs_state_t;

	typedef struct packed {
		bfs_state_t           state;
		logic                 busy_flag;
		logic                 stall;
		logic                 flash_start;
		logic                 flash_erase;
		logic [`BFS_AW-1:0]   flash_addr;
		logic                 refused;
		logic [1:0]           lock_app;
		logic [1:0]           lock_boot;
		logic                 fuse_rst;
		logic [1:0]           fuse_size;
		logic [1:0]           fuse_cnt;
		logic                 boot_ready;
		logic [`BFS_AW-1:0]   reset_vector;
		logic [`BFS_DW-1:0]   rdata;
	} bfs_regs_t;

endpackage

// File: include/bfs_region_if.sv
// Address classification bundle between the controller and a decoder.
// Assumes both ends run on the same clock; the bundle is combinational.
`timescale 1ns/10ps
`include "bfs_defines.svh"

interface bfs_region_if;
	logic [`BFS_AW-1:0] addr;
	logic [`BFS_AW-1:0] boot_start;
	logic [`BFS_AW-1:0] halt_start;
	logic               in_boot;
	logic               in_halt;

	modport decoder (
		input  addr,
		input  boot_start,
		input  halt_start,
		output in_boot,
		output in_halt
	);

	modport user (
		output addr,
		output boot_start,
		output halt_start,
		input  in_boot,
		input  in_halt
	);
endinterface

// File: rtl/bfs_ctrl.sv
// Boot flash section controller: gates store-program operations, stalls
// the core or blocks the concurrent-read region, picks the reset vector.
// Assumes a core on the same clock and a flash macro that pulses done.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "bfs_defines.svh"

module bfs_ctrl #(
	parameter logic [`BFS_AW-1:0] HALT_WORDS = `BFS_HALT_WORDS
) (
	input  wire logic                ref_clk_i,
	input  wire logic                nrst_i,
	input  wire logic [`BFS_RAW-1:0] reg_addr_i,
	input  wire logic [`BFS_DW-1:0]  reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic      [`BFS_DW-1:0]  reg_rdata_o,
	input  wire logic [1:0]          boot_size_fuses_i,
	input  wire logic                boot_reset_fuse_i,
	input  wire logic                core_store_i,
	input  wire bfs_pkg::bfs_op_t    core_op_i,
	input  wire logic [`BFS_AW-1:0]  core_pc_i,
	input  wire logic [`BFS_AW-1:0]  core_target_i,
	input  wire logic                flash_done_i,
	output logic                     flash_start_o,
	output logic                     flash_erase_o,
	output logic      [`BFS_AW-1:0]  flash_addr_o,
	output logic                     core_stall_o,
	output logic                     crr_block_o,
	output logic                     store_refused_o,
	output logic      [`BFS_AW-1:0]  reset_vector_o,
	output logic                     boot_ready_o
);

	// ****************************************************************
	// Fuse synchroniser and region decoders
	// ****************************************************************
	logic [2:0]            fuse_sync;
	logic [`BFS_AW-1:0]    boot_start;
	logic [`BFS_AW-1:0]    halt_start;
	bfs_pkg::bfs_regs_t    r_reg;
	bfs_pkg::bfs_regs_t    r_next;

	bfs_sync #(
		.W (3)
	) u_fuse_sync (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.async_i   ({boot_reset_fuse_i, boot_size_fuses_i}),
		.sync_o    (fuse_sync)
	);

	// Size clamp keeps a large boot setting from spilling out of the halting region
	function automatic logic [`BFS_AW-1:0] boot_start_of(input logic [1:0] sz);
		logic [`BFS_AW-1:0] w;
		case (sz)
			2'h0: w = `BFS_BOOT_WORDS_0;
			2'h1: w = `BFS_BOOT_WORDS_1;
			2'h2: w = `BFS_BOOT_WORDS_2;
			default: w = `BFS_BOOT_WORDS_3;
		endcase
		if (w > HALT_WORDS) begin
			w = HALT_WORDS;
		end
		boot_start_of = {`BFS_AW{1'b0}} - w;
	endfunction

	// Boundary follows only the latched fuse copy
	assign boot_start = boot_start_of(r_reg.fuse_size);
	assign halt_start = {`BFS_AW{1'b0}} - HALT_WORDS;

	bfs_region_if pc_rgn ();
	bfs_region_if tgt_rgn ();

	assign pc_rgn.addr        = core_pc_i;
	assign pc_rgn.boot_start  = boot_start;
	assign pc_rgn.halt_start  = halt_start;
	assign tgt_rgn.addr       = core_target_i;
	assign tgt_rgn.boot_start = boot_start;
	assign tgt_rgn.halt_start = halt_start;

	bfs_region_decode u_pc_dec (
		.rgn (pc_rgn)
	);

	bfs_region_decode u_tgt_dec (
		.rgn (tgt_rgn)
	);

	// ****************************************************************
	// Protection
	// ****************************************************************
	logic tgt_locked;
	logic store_ok;

	always_comb begin
		if (tgt_rgn.in_boot) begin
			tgt_locked = !r_reg.lock_boot[`BFS_LOCK_WR_BIT];
		end else begin
			tgt_locked = !r_reg.lock_app[`BFS_LOCK_WR_BIT];
		end
	end

	// Any unlocked target address is accepted once the fuses are latched and the fetch came from the boot region
	assign store_ok = pc_rgn.in_boot && !tgt_locked && r_reg.boot_ready;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		r_next             = r_reg;
		r_next.flash_start = 1'b0;
		r_next.refused     = 1'b0;
		r_next.rdata       = '0;

		// Fuses are latched once after reset; nothing else writes them
		if (!r_reg.boot_ready) begin
			if (r_reg.fuse_cnt != `BFS_FUSE_SETTLE) begin
				r_next.fuse_cnt = r_reg.fuse_cnt + 2'h1;
			end else begin
				r_next.fuse_size  = fuse_sync[1:0];
				r_next.fuse_rst   = fuse_sync[2];
				r_next.boot_ready = 1'b1;
				if (!fuse_sync[2]) begin
					r_next.reset_vector = boot_start_of(fuse_sync[1:0]);
				end else begin
					r_next.reset_vector = `BFS_APP_RESET_ADDR;
				end
			end
		end

		// Clear comes first so a same-cycle start keeps the flag set
		if (reg_wr_i && reg_addr_i == `BFS_REG_CTRL && reg_wdata_i[`BFS_CTRL_CLEAR]
				&& r_reg.state == bfs_pkg::BFS_IDLE) begin
			r_next.busy_flag = 1'b0;
		end
		// Lock bits can only be programmed towards zero
		if (reg_wr_i && reg_addr_i == `BFS_REG_LOCK) begin
			r_next.lock_app  = r_reg.lock_app & reg_wdata_i[`BFS_LOCK_APP_LSB +: 2];
			r_next.lock_boot = r_reg.lock_boot & reg_wdata_i[`BFS_LOCK_BOOT_LSB +: 2];
		end

		case (r_reg.state)
			bfs_pkg::BFS_IDLE: begin
				if (core_store_i) begin
					if (store_ok) begin
						r_next.flash_start = 1'b1;
						r_next.flash_erase = (core_op_i == bfs_pkg::BFS_OP_ERASE);
						r_next.flash_addr  = core_target_i;
						if (tgt_rgn.in_halt) begin
							r_next.state = bfs_pkg::BFS_RUN_HALT;
							r_next.stall = 1'b1;
						end else begin
							r_next.state     = bfs_pkg::BFS_RUN_CRR;
							r_next.busy_flag = 1'b1;
						end
					end else begin
						r_next.refused = 1'b1;
					end
				end
			end
			bfs_pkg::BFS_RUN_CRR: begin
				// Core keeps running here; a second store is refused
				r_next.refused = core_store_i;
				if (flash_done_i) begin
					r_next.state = bfs_pkg::BFS_IDLE;
				end
			end
			bfs_pkg::BFS_RUN_HALT: begin
				if (flash_done_i) begin
					r_next.state = bfs_pkg::BFS_IDLE;
					r_next.stall = 1'b0;
				end
			end
			default: begin
				r_next.state = bfs_pkg::BFS_IDLE;
				r_next.stall = 1'b0;
			end
		endcase

		if (reg_rd_i) begin
			case (reg_addr_i)
				`BFS_REG_CTRL: begin
					r_next.rdata[`BFS_CTRL_BUSY]   = r_reg.busy_flag;
					r_next.rdata[`BFS_CTRL_ACTIVE] = (r_reg.state != bfs_pkg::BFS_IDLE);
					r_next.rdata[`BFS_CTRL_STALL]  = r_reg.stall;
					r_next.rdata[`BFS_CTRL_READY]  = r_reg.boot_ready;
				end
				`BFS_REG_LOCK: begin
					r_next.rdata[`BFS_LOCK_APP_LSB +: 2]  = r_reg.lock_app;
					r_next.rdata[`BFS_LOCK_BOOT_LSB +: 2] = r_reg.lock_boot;
				end
				`BFS_REG_FUSE: begin
					r_next.rdata[1:0]                 = r_reg.fuse_size;
					r_next.rdata[`BFS_FUSE_RST_BIT]   = r_reg.fuse_rst;
					r_next.rdata[`BFS_FUSE_READY_BIT] = r_reg.boot_ready;
				end
				default: begin
					r_next.rdata = '0;
				end
			endcase
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg              <= '0;
			r_reg.state        <= bfs_pkg::BFS_IDLE;
			r_reg.lock_app     <= `BFS_LOCK_RESET;
			r_reg.lock_boot    <= `BFS_LOCK_RESET;
			r_reg.fuse_rst     <= 1'b1;
			r_reg.fuse_size    <= `BFS_FUSE_SIZE_RESET;
			r_reg.reset_vector <= `BFS_APP_RESET_ADDR;
		end else begin
			r_reg <= r_next;
		end
	end

	assign reg_rdata_o     = r_reg.rdata;
	assign flash_start_o   = r_reg.flash_start;
	assign flash_erase_o   = r_reg.flash_erase;
	assign flash_addr_o    = r_reg.flash_addr;
	assign core_stall_o    = r_reg.stall;
	assign crr_block_o     = r_reg.busy_flag;
	assign store_refused_o = r_reg.refused;
	assign reset_vector_o  = r_reg.reset_vector;
	assign boot_ready_o    = r_reg.boot_ready;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	logic idle_store;
	assign idle_store = core_store_i && r_reg.state == bfs_pkg::BFS_IDLE && r_reg.boot_ready;

	property p_app_no_start;
		core_store_i && !pc_rgn.in_boot |=> !flash_start_o;
	endproperty
	a_app_no_start: assert property (p_app_no_start) else $error("store from application started flash");

	// Fuses not yet latched means the boundary is unknown, so nothing may start
	property p_early_refused;
		core_store_i && !boot_ready_o |=> store_refused_o && !flash_start_o;
	endproperty
	a_early_refused: assert property (p_early_refused) else $error("store before ready not refused");

	property p_boot_any_target;
		idle_store && pc_rgn.in_boot && !tgt_locked
			|=> flash_start_o && flash_addr_o == $past(core_target_i);
	endproperty
	a_boot_any_target: assert property (p_boot_any_target) else $error("boot store not started");

	property p_boundary_fixed;
		boot_ready_o |=> $stable(r_reg.fuse_size) && $stable(boot_start);
	endproperty
	a_boundary_fixed: assert property (p_boundary_fixed) else $error("boot boundary moved");

	property p_app_lock;
		idle_store && pc_rgn.in_boot && !tgt_rgn.in_boot && !r_reg.lock_app[`BFS_LOCK_WR_BIT]
			|=> !flash_start_o && store_refused_o;
	endproperty
	a_app_lock: assert property (p_app_lock) else $error("application lock ignored");

	property p_boot_lock;
		idle_store && pc_rgn.in_boot && tgt_rgn.in_boot && !r_reg.lock_boot[`BFS_LOCK_WR_BIT]
			|=> !flash_start_o && store_refused_o;
	endproperty
	a_boot_lock: assert property (p_boot_lock) else $error("boot lock ignored");

	property p_crr_no_stall;
		r_reg.state == bfs_pkg::BFS_RUN_CRR |-> !core_stall_o;
	endproperty
	a_crr_no_stall: assert property (p_crr_no_stall) else $error("core stalled on concurrent work");

	sequence s_halt_start;
		idle_store && store_ok && tgt_rgn.in_halt;
	endsequence

	sequence s_halt_begun;
		core_stall_o && flash_start_o;
	endsequence

	sequence s_halt_done;
		r_reg.state == bfs_pkg::BFS_RUN_HALT && flash_done_i;
	endsequence

	property p_halt_stall;
		s_halt_start |=> s_halt_begun;
	endproperty
	a_halt_stall: assert property (p_halt_stall) else $error("halting work did not stall");

	// Operation length is set by the flash macro, so the span is checked per cycle
	property p_halt_held;
		r_reg.state == bfs_pkg::BFS_RUN_HALT |-> core_stall_o;
	endproperty
	a_halt_held: assert property (p_halt_held) else $error("stall dropped during halting work");

	property p_halt_release;
		s_halt_done |=> !core_stall_o;
	endproperty
	a_halt_release: assert property (p_halt_release) else $error("stall held after done");

	property p_crr_blocked;
		idle_store && store_ok && !tgt_rgn.in_halt |=> crr_block_o [*2];
	endproperty
	a_crr_blocked: assert property (p_crr_blocked) else $error("concurrent region left readable");

	property p_busy_reads_one;
		reg_rd_i && reg_addr_i == `BFS_REG_CTRL && crr_block_o |=> reg_rdata_o[`BFS_CTRL_BUSY];
	endproperty
	a_busy_reads_one: assert property (p_busy_reads_one) else $error("busy flag read as zero");

	property p_boot_in_halt;
		boot_start >= halt_start;
	endproperty
	a_boot_in_halt: assert property (p_boot_in_halt) else $error("boot region outside halting region");

	property p_reset_vector;
		$rose(boot_ready_o) |-> reset_vector_o ==
			(r_reg.fuse_rst ? `BFS_APP_RESET_ADDR : boot_start);
	endproperty
	a_reset_vector: assert property (p_reset_vector) else $error("wrong reset vector");

	property p_fuse_readonly;
		reg_wr_i && reg_addr_i == `BFS_REG_FUSE && boot_ready_o
			|=> $stable(r_reg.fuse_rst) && $stable(reset_vector_o);
	endproperty
	a_fuse_readonly: assert property (p_fuse_readonly) else $error("software changed a fuse");

	property p_busy_held;
		crr_block_o && !(reg_wr_i && reg_addr_i == `BFS_REG_CTRL
			&& reg_wdata_i[`BFS_CTRL_CLEAR] && r_reg.state == bfs_pkg::BFS_IDLE) |=> crr_block_o;
	endproperty
	a_busy_held: assert property (p_busy_held) else $error("busy flag dropped on its own");

endmodule

// File: rtl/bfs_region_decode.sv
// Classifies a flash word address into boot and halting regions.
// Assumes both regions sit at the top of flash and run to its last word.
`timescale 1ns/10ps

module bfs_region_decode (
	bfs_region_if.decoder rgn
);
	assign rgn.in_boot = (rgn.addr >= rgn.boot_start);
	assign rgn.in_halt = (rgn.addr >= rgn.halt_start);
endmodule

// File: rtl/bfs_sync.sv
// Two-flop synchroniser for static levels such as fuse pins.
// Assumes the inputs change rarely; no bus coherence is promised.
`timescale 1ns/10ps

module bfs_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule

// File: tb/bfs_core_model.sv
// Partner model: a processor core that issues store-program instructions.
// Assumes the controller takes core_store_i on the rising clock edge.
`timescale 1ns/10ps
`include "bfs_defines.svh"

module bfs_core_model (
	input  wire logic          ref_clk_i,
	input  wire logic          stall_i,
	input  wire logic          crr_block_i,
	output logic               store_o,
	output bfs_pkg::bfs_op_t   op_o,
	output logic [`BFS_AW-1:0] pc_o,
	output logic [`BFS_AW-1:0] target_o
);

	initial begin
		store_o = 1'b0;
		op_o = bfs_pkg::BFS_OP_ERASE;
		pc_o = '0;
		target_o = '0;
	end

	// ****************************************************************
	// Store-program issue
	// ****************************************************************
	task automatic store(input bfs_pkg::bfs_op_t op, input logic [`BFS_AW-1:0] pc, tgt);
		@(posedge ref_clk_i);
		// A halted core fetches nothing, and no fetch may hit a blocked region
		for (int i = 0; i < 1000 && (stall_i || (pc < 15'h7000 && crr_block_i)); i++) begin
			@(posedge ref_clk_i);
		end
		store_o <= 1'b1;
		op_o <= op;
		pc_o <= pc;
		target_o <= tgt;
		@(posedge ref_clk_i);
		// Stale operands would hide a late capture, so they flip once taken
		store_o <= 1'b0;
		op_o <= bfs_pkg::bfs_op_t'(~op);
		pc_o <= ~pc;
		target_o <= ~tgt;
	endtask
endmodule

// File: tb/test_boot_flash_section_control.sv
// Self-checking bench of the boot flash section controller.
// Assumes the controller, its package and bfs_core_model are compiled first.
`timescale 1ns/10ps
`include "bfs_defines.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end

module test_boot_flash_section_control;
	logic                ref_clk_i, nrst_i, reg_wr_i, reg_rd_i, flash_done_i;
	logic                boot_reset_fuse_i, core_store_i, flash_start_o, flash_erase_o;
	logic                core_stall_o, crr_block_o, store_refused_o, boot_ready_o;
	logic [`BFS_RAW-1:0] reg_addr_i;
	logic [`BFS_DW-1:0]  reg_wdata_i, reg_rdata_o, e_rd;
	logic [1:0]          boot_size_fuses_i;
	logic [`BFS_AW-1:0]  core_pc_i, core_target_i, flash_addr_o, reset_vector_o;
	bfs_pkg::bfs_op_t    core_op_i;
	logic [17:0]         e_st, act_st;
	logic [7:0]          q_rd[$];
	logic [17:0]         q_st[$];
	logic                rd_pend = 1'b0;
	int                  error_cnt = 0;
	int                  checks = 0;
	int                  seed = 32'hd96d;

	bfs_ctrl dut (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .boot_size_fuses_i(boot_size_fuses_i),
		.boot_reset_fuse_i(boot_reset_fuse_i), .core_store_i(core_store_i),
		.core_op_i(core_op_i), .core_pc_i(core_pc_i), .core_target_i(core_target_i),
		.flash_done_i(flash_done_i), .flash_start_o(flash_start_o),
		.flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o),
		.core_stall_o(core_stall_o), .crr_block_o(crr_block_o),
		.store_refused_o(store_refused_o), .reset_vector_o(reset_vector_o),
		.boot_ready_o(boot_ready_o)
	);

	bfs_core_model core (
		.ref_clk_i(ref_clk_i), .stall_i(core_stall_o), .crr_block_i(crr_block_o),
		.store_o(core_store_i), .op_o(core_op_i), .pc_o(core_pc_i), .target_o(core_target_i)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		error_cnt++;
		$display("timeout reached");
		stop_test();
	end

	// ****************************************************************
	// Result watcher: oldest note against each answer that appears
	// ****************************************************************
	assign act_st = {flash_start_o, store_refused_o, flash_start_o & flash_erase_o,
		flash_start_o ? flash_addr_o : 15'h0000};

	always @(negedge ref_clk_i) begin
		if (rd_pend) begin
			e_rd = q_rd.size() ? q_rd.pop_front() : 'x;
			`CHK("read data", e_rd, reg_rdata_o)
		end
		rd_pend = reg_rd_i;
		if (flash_start_o || store_refused_o) begin
			e_st = q_st.size() ? q_st.pop_front() : 'x;
			`CHK("store result", e_st, act_st)
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [14:0] bsz(input logic [1:0] c);
		return c == 2'h0 ? 15'h1000 : c == 2'h1 ? 15'h0800 : c == 2'h2 ? 15'h0400 : 15'h0200;
	endfunction

	function automatic logic [14:0] rnd(input int unsigned m);
		return 15'($unsigned($random(seed)) % m);
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic reset_dut(input logic [1:0] sz, input logic rf);
		@(posedge ref_clk_i);
		nrst_i <= 1'b0;
		boot_size_fuses_i <= sz;
		boot_reset_fuse_i <= rf;
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
	endtask

	task automatic wait_ready();
		for (int i = 0; i < 10 && boot_ready_o !== 1'b1; i++) @(negedge ref_clk_i);
		`CHK("ready", 1'b1, boot_ready_o)
	endtask

	task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_read(input logic [1:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		q_rd.push_back(e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
	endtask

	// One store with its whole flash operation; extra pokes it mid-run
	task automatic run_store(input logic [14:0] pc, tgt, input bit ok, extra);
		logic op;
		logic halt;
		op = 1'($random(seed));
		halt = tgt >= 15'h7000;
		q_st.push_back({ok, !ok, ok & !op, ok ? tgt : 15'h0000});
		core.store(bfs_pkg::bfs_op_t'(op), pc, tgt);
		if (ok) begin
			repeat (3 + rnd(8)) begin
				@(negedge ref_clk_i);
				`CHK("stall", halt, core_stall_o)
				`CHK("block", !halt, crr_block_o)
			end
			if (extra) begin
				q_st.push_back({2'b01, 16'h0000});
				core.store(bfs_pkg::bfs_op_t'(op), pc, tgt);
				reg_write(`BFS_REG_CTRL, 8'h02);
				reg_read(`BFS_REG_CTRL, 8'h15);
			end
			@(posedge ref_clk_i);
			flash_done_i <= 1'b1;
			@(posedge ref_clk_i);
			flash_done_i <= 1'b0;
		end
		@(negedge ref_clk_i);
		`CHK("stall end", 1'b0, core_stall_o)
		`CHK("block held", ok & !halt, crr_block_o)
		if (ok & !halt) begin
			reg_read(`BFS_REG_CTRL, 8'h11);
			reg_write(`BFS_REG_CTRL, 8'h02);
			@(negedge ref_clk_i);
			`CHK("block cleared", 1'b0, crr_block_o)
			reg_read(`BFS_REG_CTRL, 8'h10);
		end
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [14:0] bs;
		logic [1:0]  sz;
		logic        rf;
		logic [7:0]  lk;
		nrst_i = 1'b0;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		flash_done_i = 1'b0;
		boot_size_fuses_i = 2'h3;
		boot_reset_fuse_i = 1'b1;
		for (int k = 0; k < 4; k++) begin
			sz = 2'(k);
			rf = k[0];
			bs = 15'h0000 - bsz(sz);
			reset_dut(sz, rf);
			if (k == 0) begin
				run_store(bs, bs, 1'b0, 1'b0);
			end
			wait_ready();
			`CHK("reset vector", rf ? 15'h0000 : bs, reset_vector_o)
			reg_read(`BFS_REG_FUSE, {5'h01, rf, sz});
			@(posedge ref_clk_i);
			boot_size_fuses_i <= ~sz;
			boot_reset_fuse_i <= ~rf;
			reg_write(`BFS_REG_FUSE, 8'hFF);
			reg_read(`BFS_REG_FUSE, {5'h01, rf, sz});
			run_store(bs - 15'h0001, bs, 1'b0, 1'b0);
			run_store(bs + rnd(bsz(sz)), bs + rnd(bsz(sz)), 1'b1, 1'b0);
			run_store(bs, rnd(15'h7000), 1'b1, k == 3);
			reg_read(2'h3, 8'h00);
			`CHK("vector kept", rf ? 15'h0000 : bs, reset_vector_o)
			$display("test fuse setting %0d done", k);
		end
		for (int i = 0; i < 2; i++) begin
			lk = i ? 8'h0B : 8'h0E;
			bs = 15'h7E00;
			reset_dut(2'h3, 1'b1);
			wait_ready();
			reg_read(`BFS_REG_LOCK, 8'h0F);
			reg_write(`BFS_REG_LOCK, lk);
			reg_write(`BFS_REG_LOCK, 8'h0F);
			reg_read(`BFS_REG_LOCK, lk);
			run_store(bs, rnd(bs), i == 1, 1'b0);
			run_store(bs, bs + rnd(15'h0200), i == 0, 1'b0);
			$display("test lock set %0d done", i);
		end
		@(negedge ref_clk_i);
		`CHK("notes left", 0, q_rd.size() + q_st.size())
		stop_test();
	end
endmodule
